// [core/adcsr_ctrl.sv]
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps

// How it works
// - a write to the sequence control register stops the running sequence and starts none.
// - the sequence control register can be read and written at any time.
// - bits 6..3 give the length, 0000 and any code with bit 6 set mean eight conversions.
// - after reset the length code is 0100, four conversions.
// - with wrap clear, the nth conversion of a sequence goes to the nth result register.
// - with wrap set, the result position runs on across the sequences of a scan and wraps after the last.
// - the status register shows the position that the next result will take.
// - an abort or any control write clears the position, so a new sequence starts at zero.
// - each result register has a complete flag that shows it holds fresh data.
// - bits 1..0 pick the freeze reaction: run on, reserved, finish then halt, halt at once.
module adcsr_ctrl (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic                           hsel,
  input  wire logic [7:0]                     haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  input  wire adcsr_pkg::adcsr_conv_t         conv_in,
  input  wire logic                           freeze_pin,
  output logic                                conv_req,
  output logic                                irq
);

  adcsr_pkg::adcsr_cap_t     cap_r;
  logic                      rd_pend_r;
  logic [6:0]                seq_ctrl_r;
  logic                      scan_r;
  adcsr_pkg::adcsr_state_t   state_r;
  logic [2:0]                cc_r;
  logic [2:0]                seq_cnt_r;
  logic [adcsr_pkg::NRES-1:0] ccf_r;
  logic [adcsr_pkg::RES_W-1:0] res_r [adcsr_pkg::NRES];
  logic [adcsr_pkg::EV_W-1:0] irq_stat_r;
  logic [adcsr_pkg::EV_W-1:0] irq_mask_r;
  logic                      frz_meta_r;
  logic                      frz_r;
  logic                      conv_req_r;
  logic                      hready_r;
  logic [31:0]               hrdata_r;
  logic                      irq_r;

  logic                      addr_ok;
  logic                      wr_now;
  logic                      wr_ctrl;
  logic                      wr_start;
  logic                      wr_any_ctrl;
  logic                      go;
  logic                      take;
  logic                      seq_end;
  logic [3:0]                len;
  logic                      wrap;
  logic [1:0]                frz_mode;
  logic                      halt;
  logic [adcsr_pkg::EV_W-1:0] ev;
  logic [31:0]               rdata;

  // address phase of a transfer
  assign addr_ok = hsel & htrans[1] & hready;

  // latch address phase; writes finish in one data cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_r <= '0;
    end else if (hready_r) begin
      cap_r.valid <= addr_ok;
      cap_r.write <= hwrite;
      cap_r.addr  <= haddr;
    end
  end

  // reads take one wait state so the data is never stale
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_pend_r <= 1'b0;
      hready_r  <= 1'b1;
    end else begin
      rd_pend_r <= addr_ok & ~hwrite & hready_r;
      hready_r  <= ~(addr_ok & ~hwrite & hready_r);
    end
  end

  assign wr_now      = cap_r.valid & cap_r.write;
  assign wr_ctrl     = wr_now & (cap_r.addr == adcsr_pkg::A_SEQ_CTRL);
  assign wr_start    = wr_now & (cap_r.addr == adcsr_pkg::A_START);
  assign wr_any_ctrl = wr_ctrl | wr_start;
  assign go          = wr_start & hwdata[adcsr_pkg::START_BIT];

  // control register, writable in any state; bit 7 not stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_ctrl_r <= adcsr_pkg::SEQ_CTRL_RST;
    end else if (wr_ctrl) begin
      seq_ctrl_r <= hwdata[6:0];
    end
  end

  assign len      = adcsr_pkg::seq_len(seq_ctrl_r[adcsr_pkg::SEQ_LEN_LSB +: 4]);
  assign wrap     = seq_ctrl_r[adcsr_pkg::WRAP_BIT];
  assign frz_mode = seq_ctrl_r[adcsr_pkg::FRZ_LSB +: 2];

  // freeze is a debug pin: two flops before use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frz_meta_r <= 1'b0;
      frz_r      <= 1'b0;
    end else begin
      frz_meta_r <= freeze_pin;
      frz_r      <= frz_meta_r;
    end
  end

  // reserved code behaves like run on, the safe reading
  always_comb begin
    halt = 1'b0;
    if (frz_r && frz_mode == adcsr_pkg::FRZ_NOW) begin
      halt = 1'b1;
    end else if (frz_r && frz_mode == adcsr_pkg::FRZ_FINISH) begin
      halt = ~conv_req_r | conv_in.done;
    end
  end

  // a result counts only while it was asked for
  assign take    = conv_req_r & conv_in.done & (state_r == adcsr_pkg::ST_RUN);
  assign seq_end = take & (({1'b0, seq_cnt_r} + 4'h1) == len);

  // sequencer; control writes abort and only start launches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= adcsr_pkg::ST_IDLE;
      scan_r  <= 1'b0;
    end else if (wr_ctrl) begin
      state_r <= adcsr_pkg::ST_IDLE;
    end else if (wr_start) begin
      scan_r  <= hwdata[adcsr_pkg::SCAN_BIT];
      state_r <= go ? adcsr_pkg::ST_RUN : adcsr_pkg::ST_IDLE;
    end else begin
      case (state_r)
        adcsr_pkg::ST_IDLE: begin
          state_r <= adcsr_pkg::ST_IDLE;
        end
        adcsr_pkg::ST_RUN: begin
          if (seq_end && !scan_r) begin
            state_r <= adcsr_pkg::ST_IDLE;
          end else if (halt && !take) begin
            state_r <= adcsr_pkg::ST_HALT;
          end else if (halt && take) begin
            state_r <= adcsr_pkg::ST_HALT;
          end
        end
        adcsr_pkg::ST_HALT: begin
          if (!frz_r) begin
            state_r <= adcsr_pkg::ST_RUN;
          end
        end
        default: begin
          state_r <= adcsr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // held low while frozen in the halt state
  function automatic logic frz_halted();
    return (state_r == adcsr_pkg::ST_HALT) & frz_r;
  endfunction

  // request level to the analog core; dropped at once on halt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_req_r <= 1'b0;
    end else if (wr_any_ctrl) begin
      conv_req_r <= go;
    end else if (seq_end && !scan_r) begin
      conv_req_r <= 1'b0;
    end else begin
      conv_req_r <= (state_r != adcsr_pkg::ST_IDLE) & ~halt & ~frz_halted();
    end
  end

  // position in sequence and result position
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_cnt_r <= 3'h0;
      cc_r      <= 3'h0;
    end else if (wr_any_ctrl) begin
      seq_cnt_r <= 3'h0;
      cc_r      <= 3'h0;
    end else if (take) begin
      seq_cnt_r <= seq_end ? 3'h0 : seq_cnt_r + 3'h1;
      if (wrap) begin
        cc_r <= cc_r + 3'h1;
      end else begin
        cc_r <= seq_end ? 3'h0 : seq_cnt_r + 3'h1;
      end
    end
  end

  // result file and fresh-data flags; a start clears the flags unless a result is taken in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ccf_r <= '0;
    end else if (take) begin
      ccf_r[cc_r] <= 1'b1;
    end else if (go) begin
      ccf_r <= '0;
    end
  end

  // results need no reset; the flags say which hold data
  always_ff @(posedge clk) begin
    if (take) begin
      res_r[cc_r] <= conv_in.data;
    end
  end

  // interrupt events
  always_comb begin
    ev = '0;
    ev[adcsr_pkg::EV_SEQ]  = seq_end;
    ev[adcsr_pkg::EV_CONV] = take;
    ev[adcsr_pkg::EV_ABRT] = wr_any_ctrl & (state_r != adcsr_pkg::ST_IDLE);
  end

  // sticky status, write one to clear; a new event wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r <= '0;
    end else if (wr_now && cap_r.addr == adcsr_pkg::A_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~hwdata[adcsr_pkg::EV_W-1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_r <= '0;
    end else if (wr_now && cap_r.addr == adcsr_pkg::A_IRQ_MASK) begin
      irq_mask_r <= hwdata[adcsr_pkg::EV_W-1:0];
    end
  end

  // irq lags status by one cycle, kept registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (cap_r.addr)
      adcsr_pkg::A_SEQ_CTRL: rdata = {25'h0, seq_ctrl_r};
      adcsr_pkg::A_STATUS:   rdata = {16'h0, ccf_r, 2'h0, state_r, 1'b0, cc_r};
      adcsr_pkg::A_IRQ_STAT: rdata = {29'h0, irq_stat_r};
      adcsr_pkg::A_IRQ_MASK: rdata = {29'h0, irq_mask_r};
      adcsr_pkg::A_START:    rdata = {30'h0, scan_r, 1'b0};
      default: begin
        if (cap_r.addr >= adcsr_pkg::A_RESULT0 && cap_r.addr <= adcsr_pkg::A_RESULT7) begin
          rdata = {22'h0, res_r[cap_r.addr[4:2]]};
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= rdata;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hready_r;
  assign hresp     = 1'b0;
  assign conv_req  = conv_req_r;
  assign irq       = irq_r;

  // checks

  a_ctrl_aborts: assert property (@(posedge clk) disable iff (!nrst)
    wr_ctrl |=> state_r == adcsr_pkg::ST_IDLE && !conv_req_r)
    else $error("control write did not abort");

  a_ctrl_nostart: assert property (@(posedge clk) disable iff (!nrst)
    wr_ctrl && state_r == adcsr_pkg::ST_IDLE |=> ##1 !conv_req_r)
    else $error("control write started a sequence");

  a_ctrl_written: assert property (@(posedge clk) disable iff (!nrst)
    wr_ctrl |=> seq_ctrl_r == $past(hwdata[6:0]))
    else $error("control write lost");

  a_len_decode: assert property (@(posedge clk) disable iff (!nrst)
    seq_end |-> {1'b0, seq_cnt_r} == len - 4'h1 &&
      len == (seq_ctrl_r[6] || seq_ctrl_r[6:3] == 4'h0 ? 4'h8 : {1'b0, seq_ctrl_r[5:3]}))
    else $error("sequence length wrong");

  a_pos_fixed: assert property (@(posedge clk) disable iff (!nrst)
    take && !wrap |-> cc_r == seq_cnt_r)
    else $error("fixed mapping slot wrong");

  a_pos_wrap: assert property (@(posedge clk) disable iff (!nrst)
    take && wrap && !wr_any_ctrl |=> cc_r == $past(cc_r) + 3'h1)
    else $error("wrap counter did not advance");

  a_ctrl_clear: assert property (@(posedge clk) disable iff (!nrst)
    wr_any_ctrl |=> cc_r == 3'h0 && seq_cnt_r == 3'h0)
    else $error("counter not cleared");

  a_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    take |=> ccf_r[$past(cc_r)])
    else $error("complete flag missing");

  a_freeze_now: assert property (@(posedge clk) disable iff (!nrst)
    frz_r && frz_mode == adcsr_pkg::FRZ_NOW && !wr_any_ctrl |=> !conv_req_r)
    else $error("immediate freeze kept converting");

  a_top_bit_zero: assert property (@(posedge clk) disable iff (!nrst)
    rd_pend_r && cap_r.addr == adcsr_pkg::A_SEQ_CTRL |=> hready_r && hrdata_r[7] == 1'b0)
    else $error("bit 7 read nonzero");

  c_seq_done: cover property (@(posedge clk) disable iff (!nrst) seq_end && !wrap);
  c_wrap_round: cover property (@(posedge clk) disable iff (!nrst) take && wrap && cc_r == 3'h7);
  c_abort_run: cover property (@(posedge clk) disable iff (!nrst)
    wr_ctrl && state_r == adcsr_pkg::ST_RUN);
  c_halted: cover property (@(posedge clk) disable iff (!nrst) state_r == adcsr_pkg::ST_HALT);

endmodule // adcsr_ctrl

// [inc/adcsr_pkg.sv]
package adcsr_pkg;

  // byte addresses; the sequence control keeps its printed index
  localparam logic [7:0] SEQ_CTRL_IDX = 8'h03;
  localparam logic [7:0] A_SEQ_CTRL   = 8'(SEQ_CTRL_IDX * 4);
  localparam logic [7:0] A_STATUS     = 8'h10;
  localparam logic [7:0] A_IRQ_STAT   = 8'h14;
  localparam logic [7:0] A_IRQ_MASK   = 8'h18;
  localparam logic [7:0] A_START      = 8'h1C;
  localparam logic [7:0] A_RESULT0    = 8'h20;
  localparam logic [7:0] A_RESULT7    = 8'h3C;

  // sequence control fields
  localparam int SEQ_LEN_LSB = 3;
  localparam int WRAP_BIT    = 2;
  localparam int FRZ_LSB     = 0;
  localparam logic [6:0] SEQ_CTRL_RST = 7'h20; // length code 0100

  // freeze response codes
  localparam logic [1:0] FRZ_RUN    = 2'h0;
  localparam logic [1:0] FRZ_FINISH = 2'h2;
  localparam logic [1:0] FRZ_NOW    = 2'h3;

  // start register bits
  localparam int START_BIT = 0;
  localparam int SCAN_BIT  = 1;

  // interrupt status / mask layout
  localparam int EV_SEQ  = 0;
  localparam int EV_CONV = 1;
  localparam int EV_ABRT = 2;
  localparam int EV_W    = 3;

  localparam int RES_W   = 10;
  localparam int NRES    = 8;
  localparam logic [3:0] LEN_MAX = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HALT = 2'b10
  } adcsr_state_t;

  // captured ahb address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } adcsr_cap_t;

  // result coming back from the analog core
  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] data;
  } adcsr_conv_t;

  // codes with the top bit set, and zero, mean eight conversions
  function automatic logic [3:0] seq_len(input logic [3:0] code);
    if (code[3] || code == 4'h0) begin
      return LEN_MAX;
    end
    return {1'b0, code[2:0]};
  endfunction

endpackage

// [tb/test_adc_sequence_result_control.sv]
`timescale 1ns/1ps

module test_adc_sequence_result_control;
  logic                   clk;
  logic                   nrst;
  logic                   hsel;
  logic                   hwrite;
  logic                   freeze_pin;
  logic                   hreadyout;
  logic                   hresp;
  logic                   conv_req;
  logic                   irq;
  logic [7:0]             haddr;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [31:0]            hwdata;
  logic [31:0]            hrdata;
  logic [31:0]            q;
  logic [9:0]             d;
  adcsr_pkg::adcsr_conv_t conv_in;
  int                     n_fail;
  int                     checks;
  int                     cyc;
  int                     seed;
  int                     pos;
  int                     len;
  int                     exp_res [8];

  adcsr_ctrl dut (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_in(conv_in), .freeze_pin(freeze_pin),
    .conv_req(conv_req), .irq(irq)
  );

  // free running 100 MHz clock
  always #5 clk = ~clk;

  // hang guard, far above the roughly one thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one single ahb transfer; entered just after a rising edge, read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // one conversion answered by the analog side, mirrored into the ring model
  task automatic conv();
    d = 10'($random(seed));
    do @(posedge clk); while (conv_req !== 1'b1);
    conv_in <= {1'b1, d};
    @(posedge clk);
    conv_in.done <= 1'b0;
    exp_res[pos] = d;
    pos = (pos + 1) % 8;
  endtask

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    seed = 39;
    clk = 1'b0;
    nrst = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    conv_in = '0;
    freeze_pin = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, adcsr_pkg::A_SEQ_CTRL, 32'h0000_0000);
    cmp(q, 32'h0000_0020);
    bus(1'b1, adcsr_pkg::A_SEQ_CTRL, 32'h0000_00FF);
    bus(1'b0, adcsr_pkg::A_SEQ_CTRL, 32'h0000_0000);
    cmp(q, 32'h0000_007F);
    bus(1'b0, 8'h40, 32'h0000_0000);
    cmp(q, 32'h0000_0000);
    cmp(32'(hresp), 32'h0000_0000);
    $display("test register access done");
    // every length code, irq mask toggled per code
    for (int code = 0; code < 16; code++) begin
      len = (code == 0 || code > 7) ? 8 : code;
      pos = 0;
      bus(1'b1, adcsr_pkg::A_IRQ_MASK, 32'(code % 2));
      bus(1'b1, adcsr_pkg::A_SEQ_CTRL, 32'(code * 8));
      bus(1'b1, adcsr_pkg::A_START, 32'h0000_0001);
      repeat (len) conv();
      repeat (3) @(posedge clk);
      cmp(32'(conv_req), 32'h0000_0000);
      cmp(32'(irq), 32'(code % 2));
      bus(1'b0, adcsr_pkg::A_STATUS, 32'h0000_0000);
      cmp(32'(q[15:8]), 32'((1 << len) - 1));
      for (int i = 0; i < len; i++) begin
        bus(1'b0, adcsr_pkg::A_RESULT0 + 8'(4 * i), 32'h0000_0000);
        cmp(q, 32'(exp_res[i]));
      end
      bus(1'b1, adcsr_pkg::A_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge clk);
      cmp(32'(irq), 32'h0000_0000);
    end
    $display("test sequence length done");
    // wrap mode with scan: ten results run round the eight registers
    pos = 0;
    bus(1'b1, adcsr_pkg::A_SEQ_CTRL, 32'h0000_001C);
    bus(1'b1, adcsr_pkg::A_START, 32'h0000_0003);
    repeat (10) conv();
    bus(1'b0, adcsr_pkg::A_STATUS, 32'h0000_0000);
    cmp(32'(q[2:0]), 32'(pos));
    cmp(32'(q[15:8]), 32'h0000_00FF);
    bus(1'b0, adcsr_pkg::A_START, 32'h0000_0000);
    cmp(q, 32'h0000_0002);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, adcsr_pkg::A_RESULT0 + 8'(4 * i), 32'h0000_0000);
      cmp(q, 32'(exp_res[i]));
    end
    bus(1'b1, adcsr_pkg::A_SEQ_CTRL, 32'h0000_001C);
    bus(1'b0, adcsr_pkg::A_STATUS, 32'h0000_0000);
    cmp(32'(q[5:0]), 32'h0000_0000);
    bus(1'b0, adcsr_pkg::A_IRQ_STAT, 32'h0000_0000);
    cmp(32'(q[adcsr_pkg::EV_ABRT]), 32'h0000_0001);
    cmp(32'(conv_req), 32'h0000_0000);
    bus(1'b1, adcsr_pkg::A_IRQ_STAT, 32'h0000_0007);
    $display("test wrap and abort done");
    // each freeze code with a conversion offered while frozen
    for (int f = 0; f < 4; f++) begin
      pos = 0;
      bus(1'b1, adcsr_pkg::A_SEQ_CTRL, 32'(16 + f));
      bus(1'b1, adcsr_pkg::A_START, 32'h0000_0001);
      do @(posedge clk); while (conv_req !== 1'b1);
      freeze_pin <= 1'b1;
      repeat (5) @(posedge clk);
      cmp(32'(conv_req), 32'(f != 3));
      d = 10'($random(seed));
      conv_in <= {1'b1, d};
      @(posedge clk);
      conv_in.done <= 1'b0;
      if (f != 3) begin
        exp_res[0] = d;
        pos = 1;
      end
      repeat (3) @(posedge clk);
      cmp(32'(conv_req), 32'(f < 2));
      freeze_pin <= 1'b0;
      repeat (2 - pos) conv();
      for (int i = 0; i < 2; i++) begin
        bus(1'b0, adcsr_pkg::A_RESULT0 + 8'(4 * i), 32'h0000_0000);
        cmp(q, 32'(exp_res[i]));
      end
    end
    $display("test freeze response done");
    end_sim();
  end
endmodule // test_adc_sequence_result_control
